// ===== include/css_pkg.sv
// Purpose: shared constants for the chip-select combine and E-clock stretch block
// Assumes: 250 MHz core clock, AXI4-Lite register access, one register per aligned word
// Notes:   printed offsets are register indices; byte address is four times the index
package css_pkg;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned E_HALF_NS     = 8;
  // floor: a longest half period must not grow
  localparam int unsigned E_HALF_CYCLES = (E_HALF_NS / CLK_PERIOD_NS < 1) ? 1 :
                                          E_HALF_NS / CLK_PERIOD_NS;

  // ****************************************************************
  // register indices and byte addresses
  // ****************************************************************
  localparam logic [11:0] IDX_STRETCH   = 12'h05A;
  localparam logic [11:0] IDX_G1_CTRL   = 12'h05D;
  localparam logic [11:0] IDX_G2_ADDR   = 12'h05E;
  localparam logic [11:0] IDX_G2_CTRL   = 12'h05F;
  localparam logic [11:0] IDX_MISC_CFG  = 12'h060;
  localparam logic [11:0] IDX_STATUS    = 12'h061;
  localparam logic [11:0] ADDR_STRETCH  = IDX_STRETCH  << 2;
  localparam logic [11:0] ADDR_G1_CTRL  = IDX_G1_CTRL  << 2;
  localparam logic [11:0] ADDR_G2_ADDR  = IDX_G2_ADDR  << 2;
  localparam logic [11:0] ADDR_G2_CTRL  = IDX_G2_CTRL  << 2;
  localparam logic [11:0] ADDR_MISC_CFG = IDX_MISC_CFG << 2;
  localparam logic [11:0] ADDR_STATUS   = IDX_STATUS   << 2;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [7:0] RST_STRETCH  = 8'h00;
  localparam logic [7:0] RST_G1_CTRL  = 8'h00;
  localparam logic [7:0] RST_G2_ADDR  = 8'h00;
  localparam logic [7:0] RST_G2_CTRL  = 8'h00;
  localparam logic [1:0] RST_MISC_CFG = 2'h0;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int unsigned STR_IO_LSB   = 6;
  localparam int unsigned STR_G1_LSB   = 4;
  localparam int unsigned STR_G2_LSB   = 2;
  localparam int unsigned STR_PROG_LSB = 0;
  localparam int unsigned G1_DG2_BIT   = 7;
  localparam int unsigned GX_DPC_BIT   = 6;
  localparam int unsigned GX_POL_BIT   = 5;
  localparam int unsigned GX_AV_BIT    = 4;
  localparam int unsigned MISC_BASIS_BIT = 0;
  localparam int unsigned MISC_PRIO_BIT  = 1;

  // ****************************************************************
  // size codes and bus answers
  // ****************************************************************
  localparam logic [3:0] SZ_OFF  = 4'h0;
  localparam logic [3:0] SZ_WIN1 = 4'hA;
  localparam logic [3:0] SZ_WIN2 = 4'hB;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : css_pkg

// ===== rtl/css_eclk.sv
// Purpose: E clock generator whose high phase can be stretched by whole bus cycles
// Assumes: stretch count is stable from cycle start until E rises
// Notes:   the core clock is never gated; only the E waveform changes
`timescale 1ns/1ps
`default_nettype none
module css_eclk #(
  parameter int unsigned HALF = css_pkg::E_HALF_CYCLES
) (
  input  wire logic       i_core_clk,
  input  wire logic       i_reset_n,
  input  wire logic [1:0] i_stretch,
  output logic            o_e_high,
  output logic            o_cycle_start
);

  typedef enum logic {CSS_E_LOW, CSS_E_HIGH} css_e_state_t;

  // high phase is HALF plus one full bus cycle per stretch count
  function automatic logic [15:0] css_high_len(input logic [1:0] n);
    return 16'(HALF + 2 * HALF * n - 1);
  endfunction : css_high_len

  css_e_state_t state;
  logic [15:0]  cnt;
  logic [15:0]  limit;

  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      state         <= CSS_E_LOW;
      cnt           <= 16'h0000;
      limit         <= 16'h0000;
      o_e_high      <= 1'b0;
      o_cycle_start <= 1'b0;
    end else begin
      o_cycle_start <= 1'b0;
      unique case (state)
        CSS_E_LOW: begin
          if (cnt == 16'(HALF - 1)) begin
            state    <= CSS_E_HIGH;
            cnt      <= 16'h0000;
            limit    <= css_high_len(i_stretch);
            o_e_high <= 1'b1;
          end else begin
            cnt <= cnt + 16'h0001;
          end
        end
        CSS_E_HIGH: begin
          // stretching holds only E; timers on the core clock keep running
          if (cnt == limit) begin
            state         <= CSS_E_LOW;
            cnt           <= 16'h0000;
            o_e_high      <= 1'b0;
            o_cycle_start <= 1'b1;
          end else begin
            cnt <= cnt + 16'h0001;
          end
        end
      endcase
    end
  end

endmodule : css_eclk
`default_nettype wire

// ===== rtl/css_g2_decode.sv
// Purpose: range match for general select 2 from size code, basis and start address
// Assumes: window hits come from the expansion window logic outside
// Notes:   purely combinational; the caller samples the result at bus cycle start
`timescale 1ns/1ps
`default_nettype none
module css_g2_decode (
  input  wire logic [3:0]  i_size_code,
  input  wire logic        i_expansion_basis,
  input  wire logic [7:0]  i_start_addr,
  input  wire logic [15:0] i_cpu_addr,
  input  wire logic [18:0] i_exp_addr,
  input  wire logic        i_window1_hit,
  input  wire logic        i_window2_hit,
  output logic             o_hit
);

  // mask over address bits 18:11, bit 0 of the mask standing for address bit 11
  function automatic logic [7:0] css_cmp_mask(input logic [3:0] code, input logic basis);
    logic [7:0] m;
    m = 8'h00;
    if (basis) begin
      if (code >= 4'h1 && code <= 4'h8) begin
        m = 8'hFF << (code - 4'h1);
      end
    end else begin
      unique case (code)
        4'h1, 4'h2: m = 8'h1F;
        4'h3:       m = 8'h1C;
        4'h4:       m = 8'h18;
        4'h5:       m = 8'h10;
        default:    m = 8'h00;
      endcase
    end
    return m;
  endfunction : css_cmp_mask

  wire logic [7:0] cmp_addr;
  wire logic [7:0] cmp_mask;
  wire logic       range_hit;

  assign cmp_addr  = i_expansion_basis ? i_exp_addr[18:11] :
                     {3'h0, i_cpu_addr[15:11]};
  assign cmp_mask  = css_cmp_mask(i_size_code, i_expansion_basis);
  assign range_hit = ((cmp_addr ^ i_start_addr) & cmp_mask) == 8'h00;

  // codes above the window codes fall back to the widest range
  assign o_hit = (i_size_code == css_pkg::SZ_OFF)  ? 1'b0 :
                 (i_size_code == css_pkg::SZ_WIN1) ? i_window1_hit :
                 (i_size_code == css_pkg::SZ_WIN2) ? i_window2_hit :
                 range_hit;

endmodule : css_g2_decode
`default_nettype wire

// ===== rtl/css_top.sv
// Purpose: chip-select combining, select 2 decode and per-select E stretch with AXI4-Lite regs
// Assumes: program, general 1, I/O and window range hits are decoded elsewhere
// Notes:   bus cycle request and addresses are sampled at the start of each E low phase
`timescale 1ns/1ps
`default_nettype none
// Function
// - select 2 size code: 0 off, 1-9 sizes 2K-512K, A/B windows, C-F 512K.
// - CPU basis compares start bits 15 down to the size boundary (bits 15 to 11 for code 2 as for code 1), none from 64K.
// - expansion basis compares start bits 18 down to the boundary, none at 512K.
// - all eight combine settings are legal; program-general priority still applies first.
// - select1-onto-select2 alone drives both general areas on the select 2 pin.
// - select1-onto-program drives program or area 1 on program pin, pin 1 off.
// - select2-onto-program drives program or area 2 on program pin, pin 2 off.
// - settings 1,0,1 give program-or-area-2 on program pin, pin 1 own area.
// - select pins and E clock are timed to the E clock.
// - in-range access stretches E high by the select's count, never otherwise.
// - stretching never disturbs the core clock or anything it runs.
// - one 8-bit stretch register, two bits per select, cleared by reset.
// - each stretch field is a binary count of extra bus cycles, zero to three.
// - select 2 uses CPU address when basis bit is 0, expansion address when 1.
// - select 2 pin is active low with polarity 0, active high with 1.
// - priority bit 1 favours general selects over program select, 0 the reverse.
module css_top #(
  parameter int unsigned ADDR_W = 12,
  parameter int unsigned E_HALF = css_pkg::E_HALF_CYCLES
) (
  input  wire logic              i_core_clk,
  input  wire logic              i_reset_n,
  // bus cycle request and addresses
  input  wire logic              i_access,
  input  wire logic [15:0]       i_cpu_addr,
  input  wire logic [18:0]       i_exp_addr,
  input  wire logic              i_program_hit,
  input  wire logic              i_general1_hit,
  input  wire logic              i_io_hit,
  input  wire logic              i_window1_hit,
  input  wire logic              i_window2_hit,
  // expansion bus pins
  output logic                   o_e_clk,
  output logic                   o_program_select_pin,
  output logic                   o_general_select1_pin,
  output logic                   o_general_select2_pin,
  output logic                   o_io_select_pin,
  // AXI4-Lite slave
  input  wire logic [ADDR_W-1:0] i_awaddr,
  input  wire logic              i_awvalid,
  output logic                   o_awready,
  input  wire logic [31:0]       i_wdata,
  input  wire logic [3:0]        i_wstrb,
  input  wire logic              i_wvalid,
  output logic                   o_wready,
  output logic [1:0]             o_bresp,
  output logic                   o_bvalid,
  input  wire logic              i_bready,
  input  wire logic [ADDR_W-1:0] i_araddr,
  input  wire logic              i_arvalid,
  output logic                   o_arready,
  output logic [31:0]            o_rdata,
  output logic [1:0]             o_rresp,
  output logic                   o_rvalid,
  input  wire logic              i_rready
);

  // ****************************************************************
  // register decode
  // ****************************************************************
  function automatic logic css_is(input logic [ADDR_W-1:0] a, input logic [11:0] reg_addr);
    return a == ADDR_W'(reg_addr);
  endfunction : css_is

  function automatic logic css_mapped(input logic [ADDR_W-1:0] a);
    return css_is(a, css_pkg::ADDR_STRETCH) | css_is(a, css_pkg::ADDR_G1_CTRL) |
           css_is(a, css_pkg::ADDR_G2_ADDR) | css_is(a, css_pkg::ADDR_G2_CTRL) |
           css_is(a, css_pkg::ADDR_MISC_CFG) | css_is(a, css_pkg::ADDR_STATUS);
  endfunction : css_mapped

  logic [7:0]        chip_select_stretch_config;
  logic [7:0]        general_select1_control;
  logic [7:0]        general_select2_control;
  logic [7:0]        select2_start_addr;
  logic [1:0]        misc_config;

  // ****************************************************************
  // write channel
  // ****************************************************************
  logic              aw_held;
  logic              w_held;
  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0]       wdata_q;
  logic              wlane0_q;

  wire logic aw_take      = i_awvalid & o_awready;
  wire logic w_take       = i_wvalid & o_wready;
  wire logic do_write     = aw_held & w_held;
  wire logic next_aw_held = ~do_write & (aw_held | aw_take);
  wire logic next_w_held  = ~do_write & (w_held | w_take);
  wire logic next_bvalid  = do_write | (o_bvalid & ~i_bready);
  wire logic wr_ok        = do_write & wlane0_q & css_mapped(awaddr_q);
  wire logic wr_stretch   = wr_ok & css_is(awaddr_q, css_pkg::ADDR_STRETCH);
  wire logic wr_g1        = wr_ok & css_is(awaddr_q, css_pkg::ADDR_G1_CTRL);
  wire logic wr_g2addr    = wr_ok & css_is(awaddr_q, css_pkg::ADDR_G2_ADDR);
  wire logic wr_g2        = wr_ok & css_is(awaddr_q, css_pkg::ADDR_G2_CTRL);
  wire logic wr_misc      = wr_ok & css_is(awaddr_q, css_pkg::ADDR_MISC_CFG);

  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      aw_held   <= 1'b0;
      w_held    <= 1'b0;
      awaddr_q  <= '0;
      wdata_q   <= 32'h0000_0000;
      wlane0_q  <= 1'b0;
      o_awready <= 1'b0;
      o_wready  <= 1'b0;
      o_bvalid  <= 1'b0;
      o_bresp   <= css_pkg::RESP_OKAY;
    end else begin
      aw_held   <= next_aw_held;
      w_held    <= next_w_held;
      o_awready <= ~next_aw_held & ~next_bvalid;
      o_wready  <= ~next_w_held & ~next_bvalid;
      o_bvalid  <= next_bvalid;
      if (aw_take) begin
        awaddr_q <= i_awaddr;
      end
      if (w_take) begin
        wdata_q  <= i_wdata;
        wlane0_q <= i_wstrb[0];
      end
      if (do_write) begin
        o_bresp <= css_mapped(awaddr_q) ? css_pkg::RESP_OKAY : css_pkg::RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      chip_select_stretch_config <= css_pkg::RST_STRETCH;
      general_select1_control    <= css_pkg::RST_G1_CTRL;
      general_select2_control    <= css_pkg::RST_G2_CTRL;
      select2_start_addr         <= css_pkg::RST_G2_ADDR;
      misc_config                <= css_pkg::RST_MISC_CFG;
    end else begin
      if (wr_stretch) chip_select_stretch_config <= wdata_q[7:0];
      if (wr_g1)      general_select1_control    <= wdata_q[7:0];
      if (wr_g2addr)  select2_start_addr         <= wdata_q[7:0];
      // bit 7 of the select 2 control has no function and reads zero
      if (wr_g2)      general_select2_control    <= {1'b0, wdata_q[6:0]};
      if (wr_misc)    misc_config                <= wdata_q[1:0];
    end
  end

  // ****************************************************************
  // read channel
  // ****************************************************************
  logic [7:0] status;

  wire logic ar_take     = i_arvalid & o_arready;
  wire logic next_rvalid = ar_take | (o_rvalid & ~i_rready);
  wire logic [7:0] rd_byte =
    css_is(i_araddr, css_pkg::ADDR_STRETCH)  ? chip_select_stretch_config :
    css_is(i_araddr, css_pkg::ADDR_G1_CTRL)  ? general_select1_control :
    css_is(i_araddr, css_pkg::ADDR_G2_ADDR)  ? select2_start_addr :
    css_is(i_araddr, css_pkg::ADDR_G2_CTRL)  ? general_select2_control :
    css_is(i_araddr, css_pkg::ADDR_MISC_CFG) ? {6'h00, misc_config} :
    css_is(i_araddr, css_pkg::ADDR_STATUS)   ? status : 8'h00;

  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      o_arready <= 1'b0;
      o_rvalid  <= 1'b0;
      o_rdata   <= 32'h0000_0000;
      o_rresp   <= css_pkg::RESP_OKAY;
    end else begin
      o_arready <= ~next_rvalid;
      o_rvalid  <= next_rvalid;
      if (ar_take) begin
        o_rdata <= {24'h00_0000, rd_byte};
        o_rresp <= css_mapped(i_araddr) ? css_pkg::RESP_OKAY : css_pkg::RESP_SLVERR;
      end
    end
  end

  // ****************************************************************
  // bus cycle capture
  // ****************************************************************
  wire logic       g1_onto_g2  = general_select1_control[css_pkg::G1_DG2_BIT];
  wire logic       g1_onto_pc  = general_select1_control[css_pkg::GX_DPC_BIT];
  wire logic       g1_pol      = general_select1_control[css_pkg::GX_POL_BIT];
  wire logic       g1_av       = general_select1_control[css_pkg::GX_AV_BIT];
  wire logic       g2_onto_pc  = general_select2_control[css_pkg::GX_DPC_BIT];
  wire logic       g2_pol      = general_select2_control[css_pkg::GX_POL_BIT];
  wire logic       g2_av       = general_select2_control[css_pkg::GX_AV_BIT];
  wire logic       gen_pri     = misc_config[css_pkg::MISC_PRIO_BIT];
  wire logic       e_high;
  wire logic       cycle_start;
  wire logic       g2_hit;

  css_g2_decode u_g2_decode (
    .i_size_code       (general_select2_control[3:0]),
    .i_expansion_basis (misc_config[css_pkg::MISC_BASIS_BIT]),
    .i_start_addr      (select2_start_addr),
    .i_cpu_addr        (i_cpu_addr),
    .i_exp_addr        (i_exp_addr),
    .i_window1_hit     (i_window1_hit),
    .i_window2_hit     (i_window2_hit),
    .o_hit             (g2_hit)
  );

  logic acc_q;
  logic prog_q;
  logic g1_q;
  logic g2_q;
  logic io_q;

  // a request is seen only at the start of an E low phase, so it lines up with E
  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      acc_q  <= 1'b0;
      prog_q <= 1'b0;
      g1_q   <= 1'b0;
      g2_q   <= 1'b0;
      io_q   <= 1'b0;
    end else if (cycle_start) begin
      acc_q  <= i_access;
      prog_q <= i_access & i_program_hit;
      g1_q   <= i_access & i_general1_hit;
      g2_q   <= i_access & g2_hit;
      io_q   <= i_access & i_io_hit;
    end
  end

  // ****************************************************************
  // priority and combining
  // ****************************************************************
  wire logic prog_win = prog_q & ~(gen_pri & (g1_q | g2_q));
  wire logic g1_win   = g1_q & ~(~gen_pri & prog_q);
  wire logic g2_win   = g2_q & ~(~gen_pri & prog_q);
  wire logic comb_prog = prog_win | (g1_onto_pc & g1_win) | (g2_onto_pc & g2_win);
  wire logic comb_g2   = ~g2_onto_pc & (g2_win | (g1_onto_g2 & ~g1_onto_pc & g1_win));
  wire logic comb_g1   = g1_win & ~g1_onto_pc & ~(g1_onto_g2 & ~g2_onto_pc);

  // polarity and timing are applied to the pin, after the OR
  wire logic act_g1   = comb_g1 & (g1_av | e_high);
  wire logic act_g2   = comb_g2 & (g2_av | e_high);
  wire logic act_io   = io_q & e_high;
  wire logic next_pin_g1 = g1_pol ? act_g1 : ~act_g1;
  wire logic next_pin_g2 = g2_pol ? act_g2 : ~act_g2;

  // stretch follows the select whose range won, before any pin combining
  wire logic [1:0] sel_stretch =
    io_q     ? chip_select_stretch_config[css_pkg::STR_IO_LSB +: 2] :
    g1_win   ? chip_select_stretch_config[css_pkg::STR_G1_LSB +: 2] :
    g2_win   ? chip_select_stretch_config[css_pkg::STR_G2_LSB +: 2] :
    prog_win ? chip_select_stretch_config[css_pkg::STR_PROG_LSB +: 2] : 2'h0;

  css_eclk #(
    .HALF (E_HALF)
  ) u_eclk (
    .i_core_clk    (i_core_clk),
    .i_reset_n     (i_reset_n),
    .i_stretch     (sel_stretch),
    .o_e_high      (e_high),
    .o_cycle_start (cycle_start)
  );

  // ****************************************************************
  // pin registers
  // ****************************************************************
  // pins trail E by one core clock; the far side samples on E edges, far slower
  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      o_e_clk               <= 1'b0;
      o_program_select_pin  <= 1'b1;
      o_general_select1_pin <= 1'b1;
      o_general_select2_pin <= 1'b1;
      o_io_select_pin       <= 1'b1;
    end else begin
      o_e_clk               <= e_high;
      o_program_select_pin  <= ~comb_prog;
      o_general_select1_pin <= next_pin_g1;
      o_general_select2_pin <= next_pin_g2;
      o_io_select_pin       <= ~act_io;
    end
  end

  assign status = {2'h0, ~o_io_select_pin, ~o_program_select_pin,
                   o_general_select2_pin, o_general_select1_pin, acc_q, e_high};

endmodule : css_top
`default_nettype wire

// ===== tb/chip_select_combine_stretch_bench.sv
// Purpose: register, decode, combine and stretch scenarios for css_top
// Assumes: e half period of two core cycles
// Notes:   select levels are read back through the external device model
`timescale 1ns/1ps
`default_nettype none
module chip_select_combine_stretch_bench;
  logic i_core_clk = 1'b0, i_reset_n = 1'b0, i_access = 1'b0, i_program_hit = 1'b0;
  logic i_general1_hit = 1'b0, i_io_hit = 1'b0, i_window1_hit = 1'b0, i_window2_hit = 1'b0;
  logic [15:0] i_cpu_addr = 16'h0000;
  logic [18:0] i_exp_addr = 19'h00000;
  logic [11:0] i_awaddr = 12'h000, i_araddr = 12'h000;
  logic [31:0] i_wdata = 32'h00000000;
  logic [3:0] i_wstrb = 4'hF;
  logic i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0, i_arvalid = 1'b0, i_rready = 1'b0;
  logic o_e_clk, o_program_select_pin, o_general_select1_pin, o_general_select2_pin;
  logic o_io_select_pin, o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
  logic [1:0] o_bresp, o_rresp;
  logic [31:0] o_rdata;
  logic [3:0] sel;
  logic [7:0] len;
  int errors = 0, num_checks = 0;
  always #2 i_core_clk = ~i_core_clk;
  css_top #(.E_HALF(2)) i_dut (.*);
  css_ext_mem i_mem (.i_core_clk(i_core_clk), .i_e_clk(o_e_clk), .o_sel(sel), .o_len(len),
    .i_pins({o_io_select_pin, o_general_select2_pin, o_general_select1_pin,
             o_program_select_pin}));
  task automatic chk(input string n, input logic [33:0] s, input logic [33:0] e);
    num_checks++;
    if (s !== e) begin
      errors++;
      $display("CHECK FAILED %s exp %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic wr(input logic [11:0] a, input logic [7:0] d, output logic [1:0] r);
    int t = 0;
    @(posedge i_core_clk);
    i_awaddr <= a;
    i_wdata <= {24'h000000, d};
    i_awvalid <= 1'b1;
    i_wvalid <= 1'b1;
    i_bready <= 1'b1;
    while (t < 100) begin
      @(posedge i_core_clk);
      t++;
      if (o_awready === 1'b1) i_awvalid <= 1'b0;
      if (o_wready === 1'b1) i_wvalid <= 1'b0;
      if (o_bvalid === 1'b1) break;
    end
    r = o_bresp;
    i_bready <= 1'b0;
    if (t >= 100) errors++;
  endtask : wr
  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    int t = 0;
    @(posedge i_core_clk);
    i_araddr <= a;
    i_arvalid <= 1'b1;
    i_rready <= 1'b1;
    while (t < 100) begin
      @(posedge i_core_clk);
      t++;
      if (o_arready === 1'b1) i_arvalid <= 1'b0;
      if (o_rvalid === 1'b1) break;
    end
    d = o_rdata;
    r = o_rresp;
    i_rready <= 1'b0;
    if (t >= 100) errors++;
  endtask : rd
  // holds one access for three e periods so the last one is fully settled
  task automatic acc(input logic [4:0] h, input logic [15:0] c, input logic [18:0] x);
    int t = 0;
    @(posedge i_core_clk);
    {i_window2_hit, i_io_hit, i_window1_hit, i_general1_hit, i_program_hit} <= h;
    i_access <= 1'b1;
    i_cpu_addr <= c;
    i_exp_addr <= x;
    repeat (3) begin
      while (o_e_clk !== 1'b1 && t < 300) begin @(posedge i_core_clk); t++; end
      while (o_e_clk === 1'b1 && t < 300) begin @(posedge i_core_clk); t++; end
    end
    // idle request, so later register writes meet cleared select latches
    i_access <= 1'b0;
    @(posedge i_core_clk);
    #1;
    if (t >= 300) errors++;
  endtask : acc
  task automatic print_verdict;
    $display("errors %0d checks %0d", errors, num_checks);
    if (errors == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : print_verdict
  initial begin
    #100000;
    errors++;
    print_verdict();
  end
  logic [7:0]  gc[14] = '{8'h15, 8'h15, 8'h15, 8'h15, 8'h10, 8'h1A, 8'h1A, 8'h1C, 8'h35,
                          8'h35, 8'h11, 8'h11, 8'h11, 8'h1B};
  logic [7:0]  mc[14] = '{0, 0, 1, 1, 0, 0, 0, 1, 0, 0, 0, 0, 1, 0};
  logic [15:0] ca[14] = '{16'h0000, 16'h8000, 16'h8000, 16'h0000, 16'h0000, 16'h8000,
                          16'h0000, 16'hFFFF, 16'h0000, 16'h8000, 16'h07FF, 16'h0800,
                          16'h0000, 16'h8000};
  logic [18:0] xa[14] = '{0, 0, 0, 19'h08000, 0, 0, 0, 19'h7FFFF, 0, 0, 0, 0, 19'h00800, 0};
  logic [4:0]  hh[14] = '{0, 0, 0, 0, 0, 5'h04, 0, 0, 0, 0, 0, 0, 0, 5'h10};
  logic        ex[14] = '{0, 1, 0, 1, 1, 0, 1, 0, 1, 0, 0, 1, 1, 0};
  logic [7:0]  sv[9] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h30, 8'h02, 8'h40, 8'h20, 8'hFF};
  logic [4:0]  sh[9] = '{0, 0, 0, 0, 0, 5'h01, 5'h08, 5'h02, 0};
  logic [7:0]  sl[9] = '{2, 6, 10, 14, 2, 10, 6, 10, 2};
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    logic pe, g1e, g2e;
    repeat (6) @(posedge i_core_clk);
    i_reset_n <= 1'b1;
    rd(css_pkg::ADDR_STRETCH, d, r);
    chk("stretch reset", d, 32'h00000000);
    wr(css_pkg::ADDR_STRETCH, 8'hE4, r);
    chk("write resp", r, css_pkg::RESP_OKAY);
    rd(css_pkg::ADDR_STRETCH, d, r);
    chk("stretch readback", {r, d}, {2'h0, 32'h000000E4});
    rd(12'h300, d, r);
    chk("unmapped read", {30'h0, r}, {30'h0, css_pkg::RESP_SLVERR});
    wr(css_pkg::ADDR_STRETCH, 8'h00, r);
    for (int i = 0; i < 14; i++) begin
      wr(css_pkg::ADDR_G2_CTRL, gc[i], r);
      wr(css_pkg::ADDR_MISC_CFG, mc[i], r);
      acc(hh[i], ca[i], xa[i]);
      chk("g2 decode", {31'h0, sel[2]}, {31'h0, ex[i]});
    end
    wr(css_pkg::ADDR_MISC_CFG, 8'h00, r);
    for (int s = 0; s < 8; s++) begin
      wr(css_pkg::ADDR_G1_CTRL, {s[2], s[1], 6'h10}, r);
      wr(css_pkg::ADDR_G2_CTRL, {1'b0, s[0], 6'h15}, r);
      for (int a = 0; a < 3; a++) begin
        acc(a == 0 ? 5'h01 : (a == 1 ? 5'h02 : 5'h00), a == 2 ? 16'h0000 : 16'h8000, 0);
        pe = (a == 0) | (s[1] & (a == 1)) | (s[0] & (a == 2));
        g2e = !s[0] & ((a == 2) | (s[2] & !s[1] & (a == 1)));
        g1e = (a == 1) & !s[1] & !(s[2] & !s[0]);
        chk("combine", {28'h0, sel}, {28'h0, 1'b1, ~g2e, ~g1e, ~pe});
      end
    end
    wr(css_pkg::ADDR_G1_CTRL, 8'h10, r);
    wr(css_pkg::ADDR_G2_CTRL, 8'h15, r);
    acc(5'h03, 16'h8000, 0);
    chk("program first", {28'h0, sel}, 32'h0000000E);
    wr(css_pkg::ADDR_MISC_CFG, 8'h02, r);
    acc(5'h03, 16'h8000, 0);
    chk("general first", {28'h0, sel}, 32'h0000000D);
    acc(5'h08, 16'h8000, 0);
    chk("io select", {28'h0, sel}, 32'h00000007);
    for (int i = 0; i < 9; i++) begin
      wr(css_pkg::ADDR_STRETCH, sv[i], r);
      acc(sh[i], sh[i] == 5'h00 && i < 5 ? 16'h0000 : 16'h8000, 0);
      chk("e high", {24'h0, len}, {24'h0, sl[i]});
    end
    print_verdict();
  end
endmodule : chip_select_combine_stretch_bench
`default_nettype wire

// ===== tb/css_ext_mem.sv
// Purpose: external device that samples the select pins in step with e
// Assumes: pins given as {io, g2, g1, program}
// Notes:   reports pins and length of the last completed e high phase
`timescale 1ns/1ps
`default_nettype none
module css_ext_mem (
  input  wire logic       i_core_clk,
  input  wire logic       i_e_clk,
  input  wire logic [3:0] i_pins,
  output logic      [3:0] o_sel,
  output logic      [7:0] o_len
);
  logic [7:0] cnt = 8'h00;
  logic [3:0] sel = 4'hF;
  always @(posedge i_core_clk) begin
    if (i_e_clk === 1'b1) begin
      cnt <= cnt + 8'h01;
      sel <= i_pins;
    end else if (cnt != 8'h00) begin
      o_len <= cnt;
      o_sel <= sel;
      cnt <= 8'h00;
    end
  end
endmodule : css_ext_mem
`default_nettype wire

// ===== tb/css_props.sv
// Purpose: port-level timing and handshake checks for css_top
// Assumes: one clock domain, synchronous active-low reset
// Notes:   e high may last at most seven half periods (stretch of three)
`timescale 1ns/1ps
`default_nettype none
module css_props #(
  parameter int unsigned E_HALF = 2
) (
  input wire logic i_core_clk, i_reset_n, o_e_clk, o_program_select_pin, o_io_select_pin,
  input wire logic i_awvalid, o_awready, i_wvalid, o_wready, o_bvalid, i_bready,
  input wire logic i_arvalid, o_arready, o_rvalid, i_rready
);
  logic [7:0] hi_cnt;
  logic [7:0] lo_cnt;
  logic       run;
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_reset_n);
  always_ff @(posedge i_core_clk) begin
    hi_cnt <= (!i_reset_n || !o_e_clk) ? 8'h00 : hi_cnt + 8'h01;
    // e stays low through the release edge; count from the edge after it
    run    <= i_reset_n;
    lo_cnt <= (!run || o_e_clk) ? 8'h00 : lo_cnt + 8'h01;
  end
  a_e_high_bound: assert property (o_e_clk |-> hi_cnt < 7 * E_HALF)
    else $error("e high longer than three stretch cycles");
  // the low phase is never stretched, so the core time base stays intact
  a_e_low_fixed: assert property (lo_cnt <= E_HALF)
    else $error("e low phase too long");
  a_io_during_e: assert property (!o_io_select_pin |-> o_e_clk)
    else $error("io select active outside e high");
  a_prog_moves_low: assert property ($changed(o_program_select_pin) |-> !o_e_clk)
    else $error("program select moved during e high");
  a_wr_answer: assert property (i_awvalid && o_awready && i_wvalid && o_wready
    |=> !o_bvalid ##1 o_bvalid)
    else $error("write answer not two edges after take");
  a_wr_busy: assert property (o_bvalid |-> !o_awready && !o_wready)
    else $error("write taken while answer pending");
  a_rd_answer: assert property (i_arvalid && o_arready |=> o_rvalid)
    else $error("read answer late");
  a_rd_done: assert property (o_rvalid && i_rready |=> !o_rvalid && o_arready)
    else $error("read answer not retired");
endmodule : css_props
bind css_top css_props #(.E_HALF(E_HALF)) i_props (.i_core_clk, .i_reset_n, .o_e_clk,
  .o_program_select_pin, .o_io_select_pin, .i_awvalid, .o_awready, .i_wvalid, .o_wready,
  .o_bvalid, .i_bready, .i_arvalid, .o_arready, .o_rvalid, .i_rready);
`default_nettype wire
